// file: zero_cross_detect_logic.sv
// Digital side of the zero-cross detector with an AXI4-Lite register slave
//
// Functional notes
// R1: Level flag high while sink active.
// R2: Invert setting flips the level flag.
// R3: Edge detectors watch the inverted level.
// R4: Rising edge sets flag if enabled.
// R5: Falling edge sets flag if enabled.
// R6: Both detectors share one interrupt flag.
// R7: Request needs flag, local, peripheral, global enables.
// R8: Invert change is an edge, detector on or off.
// R9: Flag stays set until software clears it.
// R10: Edge in clear cycle keeps flag set.
// R11: Config strap picks detector on at reset.
// R12: Detection and interrupt keep running in sleep.
// R13: Sink signal synchronised before polarity logic.
`timescale 1ns/1ps
`include "zcd_map.svh"
module zero_cross_detect_logic
  import zcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sink_active,
  input wire logic detector_off_strap,
  input wire logic sleep_mode,
  output logic detector_enable,
  output logic crossing_irq,
  output logic core_wake,
  input wire logic [`ZCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ZCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // True for an offset that holds a register
  function automatic logic mapped(input logic [`ZCD_ADDR_W-1:0] a);
    mapped = (a == `ZCD_OFF_CTRL) || (a == `ZCD_OFF_FLAG) ||
             (a == `ZCD_OFF_IEN) || (a == `ZCD_OFF_CORE);
  endfunction

  // Synchroniser and edge state
  logic sync1_q, sync2_q, sync3_q, sync1_d, sync2_d, sync3_d;
  logic sink_q, sink_d;
  logic adj_q, adj_d;
  // Software state
  ctrl_t ctrl_q, ctrl_d;
  core_en_t core_q, core_d;
  logic irq_flag_q, irq_flag_d;
  logic irq_en_q, irq_en_d;
  logic init_done_q, init_done_d;
  // Bus state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [`ZCD_ADDR_W-1:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Combinational helpers
  logic sink_live, adj_now, rise_hit, fall_hit, edge_set;
  logic do_write, do_read, flag_clear;
  logic [7:0] ctrl_view;

  // Three-stage sampling of the analog sink signal, accepted once stages agree
  always_comb begin
    sync1_d = sink_active; // R13
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    // Level accepted only when stages two and three agree
    sink_d = (sync2_q == sync3_q) ? sync3_q : sink_q; // R13
  end

  // Polarity and edge detection; runs the same in sleep
  always_comb begin
    // Detector off holds the sink side low
    sink_live = sink_q & ctrl_q.detector_on; // R1
    adj_now = sink_live ^ ctrl_q.output_invert; // R2 R3 R8
    adj_d = adj_now;
    rise_hit = adj_now & ~adj_q & ctrl_q.rise_irq_enable; // R4 R12
    fall_hit = ~adj_now & adj_q & ctrl_q.fall_irq_enable; // R5 R12
    edge_set = rise_hit | fall_hit; // R6
  end

  // Status view of the control register
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`ZCD_BIT_ON] = ctrl_q.detector_on;
    ctrl_view[`ZCD_BIT_LEVEL] = adj_q; // R1 R2
    ctrl_view[`ZCD_BIT_INV] = ctrl_q.output_invert;
    ctrl_view[`ZCD_BIT_RISE] = ctrl_q.rise_irq_enable;
    ctrl_view[`ZCD_BIT_FALL] = ctrl_q.fall_irq_enable;
  end

  // Write channel: address and data taken in either order
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_write = aw_held_q && w_held_q && !bvalid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wstrb0_d = s_axi_wstrb[0];
    end
    // Response once both halves are held
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(waddr_q) ? `ZCD_RESP_OKAY : `ZCD_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Register updates from software and hardware
  always_comb begin
    ctrl_d = ctrl_q;
    core_d = core_q;
    irq_en_d = irq_en_q;
    init_done_d = 1'b1;
    flag_clear = 1'b0;
    // Strap loads the detector enable once after reset
    if (!init_done_q) begin
      ctrl_d.detector_on = ~detector_off_strap; // R11
    end
    // Software writes reach lane 0 only
    if (do_write && wstrb0_q) begin
      case (waddr_q)
        `ZCD_OFF_CTRL: begin
          ctrl_d.detector_on = wbyte_q[`ZCD_BIT_ON];
          ctrl_d.output_invert = wbyte_q[`ZCD_BIT_INV];
          ctrl_d.rise_irq_enable = wbyte_q[`ZCD_BIT_RISE];
          ctrl_d.fall_irq_enable = wbyte_q[`ZCD_BIT_FALL];
        end
        `ZCD_OFF_FLAG: begin
          flag_clear = wbyte_q[`ZCD_BIT_IRQF];
        end
        `ZCD_OFF_IEN: begin
          irq_en_d = wbyte_q[`ZCD_BIT_IRQE];
        end
        `ZCD_OFF_CORE: begin
          core_d.global_irq_enable = wbyte_q[`ZCD_BIT_GIE];
          core_d.peripheral_irq_enable = wbyte_q[`ZCD_BIT_PIE];
        end
        default: begin
          flag_clear = 1'b0;
        end
      endcase
    end
    // Sticky flag, cleared by writing one; a new edge wins over the clear
    irq_flag_d = edge_set | (irq_flag_q & ~flag_clear); // R9 R10
  end

  // Read channel: one read in flight, answered the cycle after it is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    do_read = s_axi_arvalid && s_axi_arready;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d = `ZCD_RESP_OKAY;
      // Register select at the edge the address is taken
      case (s_axi_araddr)
        `ZCD_OFF_CTRL: rdata_d = {24'h000000, ctrl_view};
        `ZCD_OFF_FLAG: rdata_d = {31'h0, irq_flag_q};
        `ZCD_OFF_IEN: rdata_d = {31'h0, irq_en_q};
        `ZCD_OFF_CORE: rdata_d = {24'h000000, core_q.global_irq_enable,
                                  core_q.peripheral_irq_enable, 6'h00};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = `ZCD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Synchroniser registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      sink_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      sink_q <= sink_d;
    end
  end

  // Previous adjusted level for the edge detectors
  always_ff @(posedge core_clk) begin
    if (rst) begin
      adj_q <= 1'b0;
    end else begin
      adj_q <= adj_d;
    end
  end

  // Software registers and the sticky flag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= '0;
      core_q <= '0;
      irq_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      init_done_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      core_q <= core_d;
      irq_flag_q <= irq_flag_d;
      irq_en_q <= irq_en_d;
      init_done_q <= init_done_d;
    end
  end

  // Write channel registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // Read channel registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Write channel handshakes and answers
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel handshakes and answers
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Interrupt gating; wake ignores peripheral and global gates so sleep can end
  assign crossing_irq = irq_flag_q & irq_en_q & core_q.peripheral_irq_enable &
                        core_q.global_irq_enable; // R7
  assign core_wake = irq_flag_q & irq_en_q & sleep_mode; // R12

  // Detector enable to the analog front end
  assign detector_enable = ctrl_q.detector_on; // R11

endmodule

// file: zcd_map.svh
// Register offsets, field positions and bus response codes of the zero-cross detector
`ifndef ZCD_MAP_SVH
`define ZCD_MAP_SVH
`define ZCD_ADDR_W 4
`define ZCD_OFF_CTRL 4'h0
`define ZCD_OFF_FLAG 4'h4
`define ZCD_OFF_IEN 4'h8
`define ZCD_OFF_CORE 4'hc
`define ZCD_BIT_ON 7
`define ZCD_BIT_LEVEL 5
`define ZCD_BIT_INV 4
`define ZCD_BIT_RISE 1
`define ZCD_BIT_FALL 0
`define ZCD_BIT_IRQF 0
`define ZCD_BIT_IRQE 0
`define ZCD_BIT_GIE 7
`define ZCD_BIT_PIE 6
`define ZCD_RESP_OKAY 2'h0
`define ZCD_RESP_SLVERR 2'h2
`endif

// file: zcd_pkg.sv
// Types shared by the zero-cross detector logic
package zcd_pkg;
  // Software settings of the detector control register
  typedef struct packed {
    logic detector_on;
    logic output_invert;
    logic rise_irq_enable;
    logic fall_irq_enable;
  } ctrl_t;
  // Global and peripheral interrupt gates
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
  } core_en_t;
endpackage

// file: zcd_asserts.sv
// Port checks for the zero-cross detector
`timescale 1ns/1ps
module zcd_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sleep_mode,
  input wire logic crossing_irq,
  input wire logic core_wake,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Wake and request gating
  wake_in_sleep_a: assert property (core_wake |-> sleep_mode)
    else $error("wake outside sleep");
  wake_follows_irq_a: assert property (crossing_irq && sleep_mode |-> core_wake)
    else $error("sleep wake missing");
  flag_sticky_a: assert property ($fell(crossing_irq) |-> $rose(s_axi_bvalid))
    else $error("request dropped without write");
  // Register bus handshakes
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  read_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind zero_cross_detect_logic zcd_asserts zcd_asserts_inst (.*);

// file: tb_zero_cross_detect_logic.sv
// Self-checking bench for the zero-cross detector
`timescale 1ns/1ps
`include "zcd_map.svh"
module tb_zero_cross_detect_logic;
  logic core_clk = 0, rst = 1, sink_active = 0, strap = 0, sleep_mode = 0;
  logic awv = 0, wv = 0, arv = 0, awr, wrd, bv, arr, rv, irq, wake, den;
  logic [3:0] awa = 4'h0, ara = 4'h0, ws = 4'hf;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0] rr, br, wresp;
  int bad_count = 0, checked = 0, cyc = 0;
  zero_cross_detect_logic zero_cross_detect_logic_inst (.core_clk(core_clk), .rst(rst),
    .sink_active(sink_active), .detector_off_strap(strap), .sleep_mode(sleep_mode),
    .detector_enable(den), .crossing_irq(irq), .core_wake(wake), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'h1));
  // Clock and hang guard
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // Bus master cycles
  task wr(input logic [3:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end while (!bv);
    wresp = br;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    d = rdata;
    r = rr;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task snk(input logic v);
    sink_active <= v;
    repeat (8) @(posedge core_clk);
  endtask
  // Scenarios
  task t_level;
    rc(`ZCD_OFF_CTRL, 32'h80);
    snk(1'h1);
    rc(`ZCD_OFF_CTRL, 32'ha0);
    wr(`ZCD_OFF_CTRL, 32'h90);
    rc(`ZCD_OFF_CTRL, 32'h90);
    rc(`ZCD_OFF_FLAG, 32'h0);
  endtask
  task t_rise;
    snk(1'h0);
    wr(`ZCD_OFF_CTRL, 32'h82);
    rc(`ZCD_OFF_FLAG, 32'h0);
    snk(1'h1);
    rc(`ZCD_OFF_FLAG, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`ZCD_OFF_IEN, 32'h1);
    wr(`ZCD_OFF_CORE, 32'hc0);
    chk(32'(irq), 32'h1);
    wr(`ZCD_OFF_CORE, 32'h80);
    chk(32'(irq), 32'h0);
    sleep_mode <= 1'h1;
    @(posedge core_clk);
    chk(32'(wake), 32'h1);
    sleep_mode <= 1'h0;
    wr(`ZCD_OFF_CORE, 32'hc0);
    wr(`ZCD_OFF_FLAG, 32'h1);
    rc(`ZCD_OFF_FLAG, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  task t_inv;
    wr(`ZCD_OFF_CTRL, 32'h91);
    rc(`ZCD_OFF_FLAG, 32'h1);
    wr(`ZCD_OFF_FLAG, 32'h1);
    snk(1'h0);
    rc(`ZCD_OFF_FLAG, 32'h0);
    snk(1'h1);
    rc(`ZCD_OFF_FLAG, 32'h1);
    wr(`ZCD_OFF_FLAG, 32'h1);
  endtask
  task t_off;
    logic [31:0] d;
    logic [1:0] r;
    wr(`ZCD_OFF_CTRL, 32'h11);
    wr(`ZCD_OFF_CTRL, 32'h01);
    rc(`ZCD_OFF_FLAG, 32'h1);
    rd(4'h2, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(`ZCD_RESP_SLVERR));
  endtask
  // Mid-run reset with the strap set: detector off until written
  task t_strap;
    strap <= 1'h1;
    rst <= 1'h1;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk(32'(den), 32'h0);
    rc(`ZCD_OFF_CTRL, 32'h0);
    wr(`ZCD_OFF_CTRL, 32'h82);
    chk(32'(den), 32'h1);
    rc(`ZCD_OFF_CTRL, 32'ha2);
  endtask
  // A rising edge still sets the flag and wakes the core in sleep; the disabled falling edge does not
  task t_sleep;
    wr(`ZCD_OFF_FLAG, 32'h1);
    wr(`ZCD_OFF_IEN, 32'h1);
    sleep_mode <= 1'h1;
    snk(1'h0);
    chk(32'(wake), 32'h0);
    snk(1'h1);
    chk(32'(wake), 32'h1);
    sleep_mode <= 1'h0;
    wr(`ZCD_OFF_FLAG, 32'h1);
    rc(`ZCD_OFF_FLAG, 32'h0);
  endtask
  // Rising edge lands in the clear cycle: the set wins
  task t_race;
    snk(1'h0);
    sink_active <= 1'h1;
    repeat (3) @(posedge core_clk);
    wr(`ZCD_OFF_FLAG, 32'h1);
    rc(`ZCD_OFF_FLAG, 32'h1);
  endtask
  // Write answers: error for a hole, no write with lane 0 off
  task t_resp;
    wr(4'h2, 32'h1);
    chk(32'(wresp), 32'(`ZCD_RESP_SLVERR));
    ws <= 4'he;
    wr(`ZCD_OFF_CTRL, 32'h00);
    chk(32'(wresp), 32'(`ZCD_RESP_OKAY));
    ws <= 4'hf;
    rc(`ZCD_OFF_CTRL, 32'ha2);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_level;
    t_rise;
    t_inv;
    t_off;
    t_strap;
    t_sleep;
    t_race;
    t_resp;
    end_of_test;
  end
endmodule
